// ### rtl/crcsc_pkg.sv
package crcsc_pkg;

   // Register byte addresses on the word-aligned bus.
   localparam logic [7:0] ADDR_DATA_LOW  = 8'h00;
   localparam logic [7:0] ADDR_DATA_HIGH = 8'h04;
   localparam logic [7:0] ADDR_ACC_HIGH  = 8'h08;
   localparam logic [7:0] ADDR_ACC_LOW   = 8'h0c;
   localparam logic [7:0] ADDR_SHF_HIGH  = 8'h10;
   localparam logic [7:0] ADDR_SHF_LOW   = 8'h14;
   localparam logic [7:0] ADDR_POLY_HIGH = 8'h18;
   localparam logic [7:0] ADDR_POLY_LOW  = 8'h1c;
   localparam logic [7:0] ADDR_SCAN_CTRL = 8'h20;
   localparam logic [7:0] ADDR_CUR_HIGH  = 8'h24;
   localparam logic [7:0] ADDR_CUR_LOW   = 8'h28;
   localparam logic [7:0] ADDR_END_HIGH  = 8'h2c;
   localparam logic [7:0] ADDR_END_LOW   = 8'h30;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h34;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h38;

   // Scanner control field positions.
   localparam int CTL_EN      = 7;
   localparam int CTL_GO      = 6;
   localparam int CTL_BUSY    = 5;
   localparam int CTL_INVALID = 4;
   localparam int CTL_INTERRUPT_MANAGEMENT    = 3;

   // Interrupt status bit positions and width.
   localparam int IRQ_DONE    = 0;
   localparam int IRQ_INVALID = 1;
   localparam int IRQ_WORD    = 2;
   localparam int IRQ_WIDTH   = 3;

   // Reset values and default memory size.
   localparam logic [15:0] RESET_WORD16 = 16'h0000;
   localparam logic [7:0]  RESET_BYTE   = 8'h00;
   localparam logic [15:0] MEM_WORDS    = 16'h4000;

   // Access modes.
   typedef enum logic [1:0] {
      MODE_CONCURRENT = 2'b00,
      MODE_BURST      = 2'b01,
      MODE_PEEK       = 2'b10,
      MODE_TRIGGERED  = 2'b11
   } crcsc_mode_e;

   // Scanner sequencer states.
   typedef enum logic [1:0] {
      SC_IDLE  = 2'b00,
      SC_FETCH = 2'b01,
      SC_WAIT  = 2'b10
   } crcsc_state_e;

endpackage

// ### rtl/crcsc_top.sv
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - data low write loads the shifter
// - accumulator writable, readable, resets zero
// - shifter visible read-only, resets zero
// - poly bits enable feedback, bit0 reads one
// - enable clear resets scanner state only
// - go plus ready fetches word to engine
// - hardware clears go past end address
// - busy while fetching or go set with engine ready
// - invalid when address beyond range or memory
// - full scan ends one past last word
// - burst stalls cpu; interrupt_management suppresses go
// - concurrent/triggered interrupt_management suppresses; peek ignores
// - suppression overrides go, never clears it
// - mode 00 conc, 01 burst, 10 peek, 11 trig
// - current address increments on every fetch
// - end address register resets zero
// - address writes ignored while go set
module crcsc_top #(
   parameter logic [15:0] MEM_SIZE = crcsc_pkg::MEM_WORDS
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [15:0] flash_addr,
   output logic             flash_req,
   input  wire logic [15:0] flash_rdata,
   input  wire logic        flash_ack,
   input  wire logic        cpu_in_interrupt,
   input  wire logic        scan_trigger,
   input  wire logic        cpu_fetch_slot,
   output logic             cpu_stall,
   output logic             irq
);
   import crcsc_pkg::*;

   // Bus phase capture and registers.
   logic        wr_pend;
   logic [7:0]  wr_addr;
   logic [15:0] crc_input_word;
   logic        data_full;
   logic [15:0] crc_running_sum;
   logic [15:0] shifter;
   logic [4:0]  shift_cnt;
   logic [15:1] poly_terms;
   logic        scan_en;
   logic        scan_go_a;
   logic        interrupt_management;
   crcsc_mode_e access_mode_field;
   logic [15:0] scan_current_address;
   logic [15:0] scan_end_address;
   logic [IRQ_WIDTH-1:0] irq_stat;
   logic [IRQ_WIDTH-1:0] irq_mask;
   crcsc_state_e state;
   logic        trig_s1;
   logic        trig_s2;
   logic        trig_q;
   logic        crc_ready;
   logic        go_eff;
   logic        fetch_ok;
   logic        start_fetch;
   logic        scan_busy;
   logic        scan_invalid;
   logic        data_wr;
   logic        engine_take;
   logic        past_end;
   logic [IRQ_WIDTH-1:0] irq_event;
   logic [31:0] next_rdata;

   // The data path is free when no word waits for the shifter.
   assign crc_ready = !data_full;

   // Interrupt-time suppression only masks the go bit seen by the sequencer.
   always_comb begin
      go_eff = scan_go_a && scan_en;
      if (interrupt_management && cpu_in_interrupt &&
          access_mode_field != MODE_PEEK) begin
         go_eff = 1'b0;
      end
   end

   // Mode decides when a fetch slot is granted.
   always_comb begin
      case (access_mode_field)
         MODE_CONCURRENT: fetch_ok = 1'b1;
         MODE_BURST:      fetch_ok = 1'b1;
         MODE_PEEK:       fetch_ok = cpu_fetch_slot;
         MODE_TRIGGERED:  fetch_ok = trig_q;
         default:         fetch_ok = 1'b0;
      endcase
   end

   assign past_end     = scan_current_address > scan_end_address;
   assign start_fetch  = (state == SC_IDLE) && go_eff && crc_ready &&
                         fetch_ok && !past_end;
   assign scan_busy    = (state != SC_IDLE) ||
                         (scan_go_a && scan_en && crc_ready);
   // A full scan leaves the address one past the last word, which is invalid.
   assign scan_invalid = past_end ||
                         (scan_current_address >= MEM_SIZE);
   assign data_wr      = wr_pend && (wr_addr == ADDR_DATA_LOW);
   assign engine_take  = (state == SC_WAIT) && flash_ack;

   // Synchronise the external trigger and keep one pending request.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_q  <= 1'b0;
      end else begin
         trig_s1 <= scan_trigger;
         trig_s2 <= trig_s1;
         if (start_fetch || !scan_en) begin
            trig_q <= 1'b0;
         end else if (trig_s2) begin
            trig_q <= 1'b1;
         end
      end
   end

   // Writes are committed in the data phase, so the slave never waits.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= RESET_BYTE;
      end else if (hready) begin
         wr_pend <= hsel && htrans[1] && hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   // Read data is registered at the address phase.
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (haddr[7:0])
         ADDR_DATA_LOW:  next_rdata[7:0] = crc_input_word[7:0];
         ADDR_DATA_HIGH: next_rdata[7:0] = crc_input_word[15:8];
         ADDR_ACC_HIGH:  next_rdata[7:0] = crc_running_sum[15:8];
         ADDR_ACC_LOW:   next_rdata[7:0] = crc_running_sum[7:0];
         ADDR_SHF_HIGH:  next_rdata[7:0] = shifter[15:8];
         ADDR_SHF_LOW:   next_rdata[7:0] = shifter[7:0];
         ADDR_POLY_HIGH: next_rdata[7:0] = poly_terms[15:8];
         ADDR_POLY_LOW:  next_rdata[7:0] = {poly_terms[7:1], 1'b1};
         ADDR_SCAN_CTRL: next_rdata[7:0] = {scan_en, scan_go_a, scan_busy,
                                  scan_invalid, interrupt_management,
                                  1'b0, access_mode_field};
         ADDR_CUR_HIGH:  next_rdata[7:0] = scan_current_address[15:8];
         ADDR_CUR_LOW:   next_rdata[7:0] = scan_current_address[7:0];
         ADDR_END_HIGH:  next_rdata[7:0] = scan_end_address[15:8];
         ADDR_END_LOW:   next_rdata[7:0] = scan_end_address[7:0];
         ADDR_IRQ_STAT:  next_rdata[IRQ_WIDTH-1:0] = irq_stat;
         ADDR_IRQ_MASK:  next_rdata[IRQ_WIDTH-1:0] = irq_mask;
         default:        next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= next_rdata;
         end
      end
   end

   // Polynomial and plain data registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         poly_terms     <= 15'h0000;
         crc_input_word <= RESET_WORD16;
         data_full      <= 1'b0;
      end else begin
         if (wr_pend && wr_addr == ADDR_POLY_HIGH) begin
            poly_terms[15:8] <= hwdata[7:0];
         end
         // Bit 0 of the low polynomial byte has no storage; it reads as one.
         if (wr_pend && wr_addr == ADDR_POLY_LOW) begin
            poly_terms[7:1] <= hwdata[7:1];
         end
         if (wr_pend && wr_addr == ADDR_DATA_HIGH) begin
            crc_input_word[15:8] <= hwdata[7:0];
         end
         if (engine_take) begin
            crc_input_word <= flash_rdata;
            data_full      <= 1'b1;
         end else if (data_wr) begin
            crc_input_word[7:0] <= hwdata[7:0];
            data_full           <= 1'b1;
         end else if (data_full && shift_cnt == 5'd0) begin
            data_full <= 1'b0;
         end
      end
   end

   // Shifter loads a full data word, then feeds the accumulator MSb first.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shifter         <= RESET_WORD16;
         shift_cnt       <= 5'd0;
         crc_running_sum <= RESET_WORD16;
      end else begin
         if (data_full && shift_cnt == 5'd0) begin
            shifter   <= crc_input_word;
            shift_cnt <= 5'd16;
         end else if (shift_cnt != 5'd0) begin
            shifter   <= {shifter[14:0], 1'b0};
            shift_cnt <= shift_cnt - 5'd1;
         end
         if (wr_pend && wr_addr == ADDR_ACC_HIGH) begin
            crc_running_sum[15:8] <= hwdata[7:0];
         end else if (wr_pend && wr_addr == ADDR_ACC_LOW) begin
            crc_running_sum[7:0] <= hwdata[7:0];
         end else if (shift_cnt != 5'd0) begin
            crc_running_sum <= {crc_running_sum[14:0], 1'b0} ^
               ((crc_running_sum[15] ^ shifter[15]) ?
                {poly_terms, 1'b1} : 16'h0000);
         end
      end
   end

   // Scanner control and address registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scan_en              <= 1'b0;
         scan_go_a            <= 1'b0;
         interrupt_management <= 1'b0;
         access_mode_field    <= MODE_CONCURRENT;
         scan_current_address <= RESET_WORD16;
         scan_end_address     <= RESET_WORD16;
      end else begin
         if (wr_pend && wr_addr == ADDR_SCAN_CTRL) begin
            scan_en              <= hwdata[CTL_EN];
            scan_go_a            <= hwdata[CTL_GO] && hwdata[CTL_EN];
            interrupt_management <= hwdata[CTL_INTERRUPT_MANAGEMENT];
            access_mode_field    <= crcsc_mode_e'(hwdata[1:0]);
         end else if (!scan_en) begin
            scan_go_a <= 1'b0;
         end else if (past_end && state == SC_IDLE) begin
            scan_go_a <= 1'b0;
         end
         if (!scan_go_a) begin
            if (wr_pend && wr_addr == ADDR_CUR_HIGH) begin
               scan_current_address[15:8] <= hwdata[7:0];
            end
            if (wr_pend && wr_addr == ADDR_CUR_LOW) begin
               scan_current_address[7:0] <= hwdata[7:0];
            end
            if (wr_pend && wr_addr == ADDR_END_HIGH) begin
               scan_end_address[15:8] <= hwdata[7:0];
            end
            if (wr_pend && wr_addr == ADDR_END_LOW) begin
               scan_end_address[7:0] <= hwdata[7:0];
            end
         end else if (start_fetch) begin
            // No stop at the top of memory; the invalid flag reports it.
            scan_current_address <= scan_current_address + 16'h0001;
         end
      end
   end

   // Fetch sequencer; disabling the scanner returns it to idle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state      <= SC_IDLE;
         flash_req  <= 1'b0;
         flash_addr <= RESET_WORD16;
      end else if (!scan_en) begin
         state     <= SC_IDLE;
         flash_req <= 1'b0;
      end else begin
         case (state)
            SC_IDLE: if (start_fetch) begin
               flash_addr <= scan_current_address;
               flash_req  <= 1'b1;
               state      <= SC_WAIT;
            end
            SC_WAIT: if (flash_ack) begin
               flash_req <= 1'b0;
               state     <= SC_IDLE;
            end
            default: state <= SC_IDLE;
         endcase
      end
   end

   // Burst holds the CPU until the address passes the end address, unless interrupt handling pauses it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_stall <= 1'b0;
      end else begin
         cpu_stall <= (access_mode_field == MODE_BURST) && go_eff &&
                      !past_end;
      end
   end

   // Sticky events; a new event wins over a write-one clear.
   assign irq_event[IRQ_DONE]    = scan_go_a && past_end && state == SC_IDLE;
   assign irq_event[IRQ_INVALID] = start_fetch &&
                                   (scan_current_address + 16'h0001 >= MEM_SIZE);
   assign irq_event[IRQ_WORD]    = engine_take;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat <= '0;
         irq_mask <= '0;
         irq      <= 1'b0;
      end else begin
         // The irq output follows a mask write one cycle later.
         if (wr_pend && wr_addr == ADDR_IRQ_MASK) begin
            irq_mask <= hwdata[IRQ_WIDTH-1:0];
         end
         irq_stat <= (irq_stat & ~((wr_pend && wr_addr == ADDR_IRQ_STAT) ?
                      hwdata[IRQ_WIDTH-1:0] : '0)) | irq_event;
         irq <= |(irq_stat & irq_mask);
      end
   end

   // Guards on the sequencer and registers, quiet while reset is held.
   a_go_cleared_end: assert property (@(posedge hclk) disable iff (!hresetn)
      scan_go_a && scan_en && past_end && state == SC_IDLE &&
      !(wr_pend && wr_addr == ADDR_SCAN_CTRL) |=> !scan_go_a)
      else $error("go not cleared past end");
   a_addr_step: assert property (@(posedge hclk) disable iff (!hresetn)
      start_fetch |=>
         scan_current_address == $past(scan_current_address) + 16'h0001)
      else $error("address did not step");
   a_addr_locked: assert property (@(posedge hclk) disable iff (!hresetn)
      scan_go_a && !start_fetch |=> $stable(scan_end_address))
      else $error("end address changed while go");
   a_supp_no_fetch: assert property (@(posedge hclk) disable iff (!hresetn)
      interrupt_management && cpu_in_interrupt &&
      access_mode_field != MODE_PEEK |-> !start_fetch)
      else $error("fetch during interrupt");
   a_supp_keeps_go: assert property (@(posedge hclk) disable iff (!hresetn)
      scan_go_a && scan_en && cpu_in_interrupt && !past_end &&
      !(wr_pend && wr_addr == ADDR_SCAN_CTRL) |=> scan_go_a)
      else $error("go cleared by interrupt");
   a_fetch_ready: assert property (@(posedge hclk) disable iff (!hresetn)
      start_fetch |=> flash_req && state == SC_WAIT)
      else $error("fetch not issued");
   a_data_load: assert property (@(posedge hclk) disable iff (!hresetn)
      data_wr && !engine_take |=> data_full)
      else $error("data write did not fill");
   a_disable_idle: assert property (@(posedge hclk) disable iff (!hresetn)
      !scan_en |=> state == SC_IDLE && !flash_req)
      else $error("scanner not reset on disable");
   a_full_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
      data_full |-> !start_fetch)
      else $error("fetch while data path full");
   a_poly_bit0: assert property (@(posedge hclk) disable iff (!hresetn)
      hready && hsel && htrans[1] && !hwrite &&
      haddr[7:0] == ADDR_POLY_LOW |=> hrdata[0])
      else $error("poly bit 0 not one");

endmodule

`default_nettype wire

// ### test/crcsc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural flash that answers each request after a wait set by lag.
module crcsc_flash_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        req,
   input  wire logic [15:0] addr,
   input  wire logic [2:0]  lag,
   output logic      [15:0] rdata,
   output logic             ack
);
   logic [2:0] wait_cnt;

   // Outside the ack cycle the data toggles, so a stale word never passes.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_cnt <= 3'h0;
         ack      <= 1'b0;
         rdata    <= 16'h0000;
      end else if (req && !ack && wait_cnt >= lag) begin
         ack      <= 1'b1;
         rdata    <= addr ^ 16'ha5c3;
         wait_cnt <= 3'h0;
      end else begin
         ack      <= 1'b0;
         rdata    <= ~rdata;
         wait_cnt <= req ? wait_cnt + 3'h1 : 3'h0;
      end
   end
endmodule

`default_nettype wire

// ### test/crcsc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module crcsc_top_tb;
   import crcsc_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, irq, cpu_stall, rd_dph;
   logic        flash_req, flash_ack, cpu_in_interrupt, scan_trigger;
   logic        cpu_fetch_slot, hreadyout, hresp, stall_seen, fl_skip;
   logic [1:0]  htrans;
   logic [2:0]  hsize, lag;
   logic [31:0] haddr, hwdata, hrdata, rnd, rs;
   logic [15:0] flash_addr, flash_rdata;
   logic [15:0] rd_q[$];
   logic [15:0] fa_q[$];
   int          bad_count, check_count, words, n;

   crcsc_top #(.MEM_SIZE(16'h0020)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .flash_addr(flash_addr), .flash_req(flash_req),
      .flash_rdata(flash_rdata), .flash_ack(flash_ack),
      .cpu_in_interrupt(cpu_in_interrupt), .scan_trigger(scan_trigger),
      .cpu_fetch_slot(cpu_fetch_slot), .cpu_stall(cpu_stall), .irq(irq));

   crcsc_flash_model flash (
      .clk(hclk), .rst_n(hresetn), .req(flash_req), .addr(flash_addr),
      .lag(lag), .rdata(flash_rdata), .ack(flash_ack));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t got %h expected %h", $time, g, e);
      end
   endtask

   // Every wait is bounded; running out ends the run as a mismatch.
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 99);
      if (k >= 99) begin bad_count++; wrap_up(); end
   endtask

   // One single AHB transfer; reads leave their expectation for the monitor.
   task automatic bus(input logic w, input logic [7:0] a, d, e, m);
      hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w;
      wait_rdy();
      htrans <= 2'b00; hwdata <= {24'h0, d};
      if (!w) begin rd_q.push_back({m, e}); rd_dph <= 1'b1; end
      wait_rdy();
      rd_dph <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, d);
      bus(1'b1, a, d, 8'h00, 8'h00);
   endtask

   task automatic rd(input logic [7:0] a, e, m);
      bus(1'b0, a, 8'h00, e, m);
   endtask

   // Runs one scan from lo to hi and waits for the done interrupt.
   task automatic scan(input logic [15:0] lo, hi, input logic [7:0] ctl);
      int i;
      wr(ADDR_IRQ_STAT, 8'h07);
      wr(ADDR_CUR_HIGH, lo[15:8]);
      wr(ADDR_CUR_LOW, lo[7:0]);
      wr(ADDR_END_HIGH, hi[15:8]);
      wr(ADDR_END_LOW, hi[7:0]);
      for (i = lo; i <= hi; i++) fa_q.push_back(16'(i));
      wr(ADDR_SCAN_CTRL, ctl | 8'hc0);
      wr(ADDR_CUR_LOW, 8'hee);
      if (cpu_in_interrupt) begin
         repeat (30) @(posedge hclk);
         cmp(32'(fa_q.size()), 32'(hi - lo + 1));
         rd(ADDR_SCAN_CTRL, 8'he8, 8'he8);
         cpu_in_interrupt <= 1'b0;
      end
      i = 0;
      while (irq !== 1'b1 && i < 5000) begin @(posedge hclk); i++; end
      if (i >= 5000) begin bad_count++; wrap_up(); end
      cmp(32'(fa_q.size()), 32'h0);
   endtask

   // The clock runs at 250 MHz.
   always #2 hclk = ~hclk;

   // Random lag, fetch slots and triggers keep the far side unpredictable.
   always @(posedge hclk) begin
      rs = lfsr(rs);
      lag <= rs[2:0];
      cpu_fetch_slot <= rs[5];
      scan_trigger <= rs[9] & rs[10];
   end

   // Read data and fetch addresses are compared to the oldest note.
   always @(posedge hclk) begin
      if (rd_dph === 1'b1 && hreadyout === 1'b1) begin
         n = rd_q.pop_front();
         cmp(hrdata[7:0] & n[15:8], n[7:0] & n[15:8]);
         cmp(hresp, 1'b0);
      end
      if (flash_req === 1'b1 && flash_ack === 1'b1) begin
         words++;
         if (!fl_skip) cmp(flash_addr, fa_q.pop_front());
      end
      if (cpu_stall === 1'b1) stall_seen = 1'b1;
   end

   initial begin
      hclk = 0; hresetn = 0; hsel = 0; hwrite = 0; htrans = 0; hsize = 3'h2;
      haddr = 0; hwdata = 0; cpu_in_interrupt = 0; scan_trigger = 0;
      cpu_fetch_slot = 0; lag = 0; rd_dph = 0; stall_seen = 0; fl_skip = 0;
      rnd = 32'h98715392; rs = 32'h98715392; words = 0;
      bad_count = 0; check_count = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      rd(ADDR_ACC_HIGH, 8'h00, 8'hff);
      rd(ADDR_ACC_LOW, 8'h00, 8'hff);
      rd(ADDR_SHF_HIGH, 8'h00, 8'hff);
      rd(ADDR_END_HIGH, 8'h00, 8'hff);
      rd(ADDR_END_LOW, 8'h00, 8'hff);
      rd(ADDR_CUR_LOW, 8'h00, 8'hff);
      rd(ADDR_SCAN_CTRL, 8'h00, 8'hff);
      $display("test reset values done");
      rnd = lfsr(rnd);
      wr(ADDR_ACC_HIGH, rnd[7:0]);
      rd(ADDR_ACC_HIGH, rnd[7:0], 8'hff);
      wr(ADDR_ACC_LOW, rnd[15:8]);
      rd(ADDR_ACC_LOW, rnd[15:8], 8'hff);
      wr(ADDR_POLY_HIGH, rnd[23:16]);
      rd(ADDR_POLY_HIGH, rnd[23:16], 8'hff);
      wr(ADDR_POLY_LOW, 8'h00);
      rd(ADDR_POLY_LOW, 8'h01, 8'hff);
      wr(ADDR_SHF_LOW, 8'hff);
      rd(ADDR_SHF_LOW, 8'h00, 8'hff);
      rd(8'h3c, 8'h00, 8'hff);
      wr(ADDR_DATA_HIGH, 8'hff);
      wr(ADDR_DATA_LOW, 8'hff);
      // The shifter takes the word one cycle after the write lands.
      @(posedge hclk);
      rd(ADDR_SHF_HIGH, 8'hff, 8'hff);
      $display("test registers done");
      wr(ADDR_IRQ_MASK, 8'h01);
      scan(16'h0010, 16'h0013, {6'h00, MODE_CONCURRENT});
      rd(ADDR_CUR_LOW, 8'h14, 8'hff);
      rd(ADDR_SCAN_CTRL, 8'h90, 8'hff);
      // The address event fires only on stepping past the top of memory.
      rd(ADDR_IRQ_STAT, 8'h05, 8'hff);
      wr(ADDR_IRQ_MASK, 8'h00);
      repeat (2) @(posedge hclk);
      cmp(irq, 1'b0);
      wr(ADDR_IRQ_MASK, 8'h01);
      scan(16'h001e, 16'h001f, {6'h00, MODE_BURST});
      rd(ADDR_CUR_LOW, 8'h20, 8'hff);
      rd(ADDR_SCAN_CTRL, 8'h91, 8'hff);
      rd(ADDR_IRQ_STAT, 8'h07, 8'hff);
      wr(ADDR_IRQ_MASK, 8'h02);
      repeat (2) @(posedge hclk);
      cmp(irq, 1'b1);
      wr(ADDR_IRQ_STAT, 8'h02);
      repeat (2) @(posedge hclk);
      cmp(irq, 1'b0);
      rd(ADDR_IRQ_STAT, 8'h05, 8'hff);
      wr(ADDR_IRQ_MASK, 8'h01);
      cmp(stall_seen, 1'b1);
      $display("test scan and interrupt done");
      for (int m = 0; m < 4; m++) scan(16'h0004, 16'h0005, 8'(m));
      cpu_in_interrupt <= 1'b1;
      scan(16'h0008, 16'h0009, 8'h08);
      $display("test modes done");
      fl_skip = 1'b1;
      wr(ADDR_CUR_HIGH, 8'h00);
      wr(ADDR_END_LOW, 8'hff);
      wr(ADDR_SCAN_CTRL, 8'hc0);
      repeat (60) @(posedge hclk);
      wr(ADDR_SCAN_CTRL, 8'h00);
      repeat (10) @(posedge hclk);
      n = words;
      repeat (100) @(posedge hclk);
      cmp(words, n);
      rd(ADDR_POLY_HIGH, rnd[23:16], 8'hff);
      rd(ADDR_SCAN_CTRL, 8'h00, 8'hc0);
      $display("test disable done");
      repeat (3) @(posedge hclk);
      wrap_up();
   end
endmodule

`default_nettype wire
